// File: verilog/tca_tlb_cache_test.sv
// tlb and cache test register access path with its tlb and cache stores
// Behaviour
// - tlb data address field returns entry data on lookup, supplies it on write
// - lookup reports the entry's lru bits as they were before the lookup
// - lookup sets the hit bit on hit, clears it on miss
// - write with hit bit set uses set select, else pseudo-lru victim
// - on lookup hit, set select reports the set that held the tag
// - set select picks the written set only when the hit bit is set
// - lookup searches by linear address and refreshes both tlb registers on a hit, only tlb data on a miss
// - tlb write allocates an entry to the control linear address
// - tlb write marks entry valid when valid bit is one, else invalid
// - attribute pairs gate lookup matching: never, zero, one, either
// - control bit 0 picks lookup when one, write when zero
// - test register moves only at privilege 0; real mode counts as 0
// - cache is 16 KB, four-way, write-back, 256 entries per set
// - cache entry holds 20-bit tag, 16 data bytes, valid, four dirty bits
// - a dirty bit per word is set when that word is written internally
// - each cache line keeps three lru bits of most recent set
// - cache line chosen by physical address bits 11 to 4
// - cache reads go via flush buffer, writes via separate fill buffer
// - tlb is 32 entries, four-way, 20-bit tag, 20-bit data
// - cache control code: buffer access, cache write, read, flush
`timescale 1ns/100ps
module tca_tlb_cache_test
  import tca_pkg::*;
(
  input  wire logic        clk,       // 50 MHz core clock
  input  wire logic        reset,     // synchronous, active high
  input  wire tca_req_type req,       // test register move
  input  wire logic        coreWr,    // internal cache word write
  input  wire logic [31:0] coreAddr,  // its physical address
  input  wire logic [31:0] coreData,  // its data
  output logic      [31:0] rdData,    // read data
  output logic             rdValid,   // read data valid pulse
  output logic             fault      // refused move pulse
);
  tca_state_type st_ff;
  tca_state_type nxt_st;
  // tlb store: tag, attributes {d,u,r}, physical address, valid, lru
  // 8 lines of 4 sets make the 32 entries
  logic [19:0] tTag  [TLB_LINES][WAYS];
  logic [19:0] tPa   [TLB_LINES][WAYS];
  logic [2:0]  tAttr [TLB_LINES][WAYS];
  logic [3:0]  tValid[TLB_LINES];
  logic [2:0]  tLru  [TLB_LINES];
  // cache store
  logic [LINE_BITS-1:0] cData [C_LINES][WAYS];
  logic [19:0]          cTag  [C_LINES][WAYS];
  logic [3:0]           cDirty[C_LINES][WAYS];
  logic [3:0]           cValid[C_LINES];
  logic [2:0]           cLru  [C_LINES];

  // ************************************************************
  // helpers
  // ************************************************************
  // pair {bit, complement}: 00 never, 01 zero, 10 one, 11 either
  function automatic logic attr_ok(input logic [1:0] p, input logic b);
    attr_ok = (p[1] & b) | (p[0] & ~b);
  endfunction
  // tree lru: b0 set0/1 recent, b1 set0 over 1, b2 set2 over 3
  function automatic logic [1:0] lru_victim(input logic [2:0] l);
    lru_victim = l[0] ? (l[2] ? 2'h3 : 2'h2) : (l[1] ? 2'h1 : 2'h0);
  endfunction
  function automatic logic [2:0] lru_touch(input logic [2:0] l,
                                           input logic [1:0] s);
    lru_touch = s[1] ? {~s[0], l[1], 1'b0} : {l[2], ~s[0], 1'b1};
  endfunction
  function automatic logic [1:0] enc4(input logic [3:0] m);
    enc4 = m[3] ? 2'h3 : m[2] ? 2'h2 : m[1] ? 2'h1 : 2'h0;
  endfunction

  // ************************************************************
  // tlb match and cache select
  // ************************************************************
  logic [31:0] tc;
  logic [2:0]  tIdx;
  logic [3:0]  tMatch;
  logic        tHit;
  logic [1:0]  tHitSet;
  logic [1:0]  tWSet;
  logic        tLookup;
  logic [7:0]  cLine;
  logic [1:0]  cSet;
  logic [7:0]  kLine;
  logic [3:0]  kMatch;
  logic [1:0]  kSet;
  logic        privOk;
  assign tc      = st_ff.tlbCtrl;
  assign tIdx    = tc[TIDX_HI:ADDR_LO];
  assign tLookup = tc[CMD_BIT];
  // tag, valid and each attribute pair must agree
  generate
    for (genvar s = 0; s < WAYS; s++) begin : g_match
      assign tMatch[s] = tValid[tIdx][s]
        & (tTag[tIdx][s] == tc[ADDR_HI:ADDR_LO])
        & attr_ok(tc[D_BIT -: 2], tAttr[tIdx][s][2])
        & attr_ok(tc[U_BIT -: 2], tAttr[tIdx][s][1])
        & attr_ok(tc[R_BIT -: 2], tAttr[tIdx][s][0]);
      assign kMatch[s] = cValid[kLine][s]
        & (cTag[kLine][s] == coreAddr[ADDR_HI:ADDR_LO]);
    end
  endgenerate
  assign tHit    = |tMatch;
  assign tHitSet = enc4(tMatch);
  // write target: explicit set or pseudo-lru victim
  assign tWSet = st_ff.tlbData[HIT_BIT] ? st_ff.tlbData[SET_HI:SET_LO]
                                        : lru_victim(tLru[tIdx]);
  assign cLine  = st_ff.cacheCtrl[LINE_HI:LINE_LO];
  assign cSet   = st_ff.cacheCtrl[SET_HI:SET_LO];
  assign kLine  = coreAddr[LINE_HI:LINE_LO];
  assign kSet   = enc4(kMatch);
  assign privOk = req.realMode | (req.cpl == 2'h0);

  // ************************************************************
  // register file and operation results
  // ************************************************************
  // results of a started operation land after bus writes and win
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.rdValid = 1'b0;
    nxt_st.fault   = 1'b0;
    nxt_st.tlbGo   = 1'b0;
    nxt_st.cacheGo = 1'b0;
    if ((req.rd | req.wr) & ~privOk) begin
      nxt_st.fault = 1'b1;
    end else if (req.rd) begin
      nxt_st.rdValid = 1'b1;
      unique case (req.sel)
        SEL_TLB_DATA: nxt_st.rdData = st_ff.tlbData;
        SEL_TLB_CTRL: nxt_st.rdData = st_ff.tlbCtrl;
        SEL_CT_CTRL:  nxt_st.rdData = st_ff.cacheCtrl;
        SEL_CT_TAG:   nxt_st.rdData = st_ff.cacheTag;
        SEL_CT_DATA:  nxt_st.rdData = st_ff.flush[{cSet, 5'h00} +: 32];
        default:      nxt_st.rdData = RST_WORD;
      endcase
    end else if (req.wr) begin
      unique case (req.sel)
        SEL_TLB_DATA: nxt_st.tlbData = req.data & TLB_DATA_MASK;
        SEL_TLB_CTRL: begin
          nxt_st.tlbCtrl = req.data & TLB_CTRL_MASK;
          nxt_st.tlbGo   = 1'b1;
        end
        SEL_CT_CTRL: begin
          nxt_st.cacheCtrl = req.data & CT_CTRL_MASK;
          nxt_st.cacheGo   = 1'b1;
        end
        SEL_CT_TAG: nxt_st.cacheTag = req.data & CT_TAG_MASK;
        SEL_CT_DATA: begin
          if (st_ff.cacheCtrl[OP_HI:0] == CT_BUF) begin
            nxt_st.fill[{cSet, 5'h00} +: 32] = req.data;
          end
        end
        default: ;
      endcase
    end
    // lookup refreshes tlb data; on a hit it also refreshes control, both from the matching entry
    if (st_ff.tlbGo & tLookup) begin
      nxt_st.tlbData[HIT_BIT]        = tHit;
      nxt_st.tlbData[LRU_HI:LRU_LO]  = tLru[tIdx];
      nxt_st.tlbData[SET_HI:SET_LO]  = tHitSet;
      if (tHit) begin
        nxt_st.tlbData[ADDR_HI:ADDR_LO] = tPa[tIdx][tHitSet];
        nxt_st.tlbCtrl[TV_BIT] = 1'b1;
        nxt_st.tlbCtrl[D_BIT -: 2] = {tAttr[tIdx][tHitSet][2],
                                      ~tAttr[tIdx][tHitSet][2]};
        nxt_st.tlbCtrl[U_BIT -: 2] = {tAttr[tIdx][tHitSet][1],
                                      ~tAttr[tIdx][tHitSet][1]};
        nxt_st.tlbCtrl[R_BIT -: 2] = {tAttr[tIdx][tHitSet][0],
                                      ~tAttr[tIdx][tHitSet][0]};
      end
    end
    // cache read moves the line to the flush buffer
    if (st_ff.cacheGo & (st_ff.cacheCtrl[OP_HI:0] == CT_READ)) begin
      nxt_st.flush    = cData[cLine][cSet];
      nxt_st.cacheTag = {cTag[cLine][cSet], 1'b0, cValid[cLine][cSet],
                         cLru[cLine], cDirty[cLine][cSet], 3'h0};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // store updates
  // ************************************************************
  // tags and data are not cleared; only valid and lru need a start
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < TLB_LINES; i++) begin
        tValid[i] <= 4'h0;
        tLru[i]   <= 3'h0;
      end
      for (int i = 0; i < C_LINES; i++) begin
        cValid[i] <= 4'h0;
        cLru[i]   <= 3'h0;
      end
    end else begin
      if (st_ff.tlbGo & tLookup & tHit) begin
        tLru[tIdx] <= lru_touch(tLru[tIdx], tHitSet);
      end else if (st_ff.tlbGo & ~tLookup) begin
        tTag[tIdx][tWSet]   <= tc[ADDR_HI:ADDR_LO];
        tPa[tIdx][tWSet]    <= st_ff.tlbData[ADDR_HI:ADDR_LO];
        tAttr[tIdx][tWSet]  <= {tc[D_BIT], tc[U_BIT], tc[R_BIT]};
        tValid[tIdx][tWSet] <= tc[TV_BIT];
        tLru[tIdx]          <= lru_touch(tLru[tIdx], tWSet);
      end
      // internal word write on a hit marks that word dirty
      if (coreWr & (|kMatch)) begin
        cData[kLine][kSet][{coreAddr[SET_HI:SET_LO], 5'h00} +: 32]
          <= coreData;
        cDirty[kLine][kSet][coreAddr[SET_HI:SET_LO]] <= 1'b1;
        cLru[kLine] <= lru_touch(cLru[kLine], kSet);
      end
      // test operations come later so they win over a core write
      if (st_ff.cacheGo) begin
        unique case (tca_cop_type'(st_ff.cacheCtrl[OP_HI:0]))
          CT_WRITE: begin
            cData[cLine][cSet]  <= st_ff.fill;
            cTag[cLine][cSet]   <= st_ff.cacheTag[ADDR_HI:ADDR_LO];
            cValid[cLine][cSet] <= st_ff.cacheTag[CV_BIT];
            cDirty[cLine][cSet] <= st_ff.cacheTag[DRT_HI:DRT_LO];
            cLru[cLine]         <= lru_touch(cLru[cLine], cSet);
          end
          CT_READ:  cLru[cLine] <= lru_touch(cLru[cLine], cSet);
          CT_FLUSH: begin
            for (int i = 0; i < C_LINES; i++) begin
              cValid[i] <= 4'h0;
            end
          end
          CT_BUF: ;
        endcase
      end
    end
  end

  assign rdData  = st_ff.rdData;
  assign rdValid = st_ff.rdValid;
  assign fault   = st_ff.fault;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_ctrlWr;
    req.wr && !req.rd && privOk && req.sel == SEL_TLB_CTRL;
  endsequence
  sequence s_lookup;
    st_ff.tlbGo && tLookup;
  endsequence
  a_priv_refuse: assert property ((req.wr | req.rd) && !privOk |=>
    fault && !rdValid && $stable(st_ff.tlbCtrl))
    else $error("privileged move not refused");
  a_ctrl_starts: assert property (s_ctrlWr |=> st_ff.tlbGo ##1 !st_ff.tlbGo)
    else $error("control write did not start one op");
  a_hit_flag: assert property (s_lookup |=>
    st_ff.tlbData[HIT_BIT] == $past(tHit))
    else $error("hit bit wrong");
  a_lru_before: assert property (s_lookup |=>
    st_ff.tlbData[LRU_HI:LRU_LO] == $past(tLru[tIdx]))
    else $error("lookup lru not prior value");
  a_hit_set: assert property ((s_lookup and tHit) |=>
    st_ff.tlbData[SET_HI:SET_LO] == $past(tHitSet)
    && st_ff.tlbData[ADDR_HI:ADDR_LO] == $past(tPa[tIdx][tHitSet]))
    else $error("hit set or address wrong");
  a_write_set: assert property (st_ff.tlbGo && !tLookup
    && st_ff.tlbData[HIT_BIT] |=>
    tTag[$past(tIdx)][$past(st_ff.tlbData[SET_HI:SET_LO])]
    == $past(tc[ADDR_HI:ADDR_LO]))
    else $error("explicit set not used");
  a_write_valid: assert property (st_ff.tlbGo && !tLookup |=>
    tValid[$past(tIdx)][$past(tWSet)] == $past(tc[TV_BIT]))
    else $error("tlb valid not written");
  a_flush_buf: assert property (st_ff.cacheGo
    && st_ff.cacheCtrl[OP_HI:0] == CT_READ |=>
    st_ff.flush == $past(cData[cLine][cSet]))
    else $error("flush buffer not loaded");
endmodule

// File: verilog/tca_pkg.sv
// package: constants and carriers for the tlb and cache test access block
package tca_pkg;
  // register selects carried by the move instruction
  localparam logic [2:0] SEL_TLB_DATA  = 3'h7;
  localparam logic [2:0] SEL_TLB_CTRL  = 3'h6;
  localparam logic [2:0] SEL_CT_CTRL   = 3'h5;
  localparam logic [2:0] SEL_CT_TAG    = 3'h4;
  localparam logic [2:0] SEL_CT_DATA   = 3'h3;
  // writable-bit masks, reserved bits read zero
  localparam logic [31:0] TLB_DATA_MASK = 32'hfffff39c;
  localparam logic [31:0] TLB_CTRL_MASK = 32'hffffffe1;
  localparam logic [31:0] CT_CTRL_MASK  = 32'h00000fff;
  localparam logic [31:0] CT_TAG_MASK   = 32'hfffff7f8;
  localparam logic [31:0] RST_WORD      = 32'h00000000;
  // shared field positions
  localparam int ADDR_HI = 31;
  localparam int ADDR_LO = 12;
  localparam int LRU_HI  = 9;
  localparam int LRU_LO  = 7;
  localparam int SET_HI  = 3;
  localparam int SET_LO  = 2;
  // tlb fields
  localparam int HIT_BIT = 4;
  localparam int TV_BIT  = 11;
  localparam int D_BIT   = 10;
  localparam int U_BIT   = 8;
  localparam int R_BIT   = 6;
  localparam int CMD_BIT = 0;
  localparam int TIDX_HI = 14;
  // cache fields
  localparam int LINE_HI = 11;
  localparam int LINE_LO = 4;
  localparam int OP_HI   = 1;
  localparam int CV_BIT  = 10;
  localparam int DRT_HI  = 6;
  localparam int DRT_LO  = 3;
  // geometry: 32 tlb entries as 8 lines of 4 sets, cache 256 x 4 x 16 B
  localparam int WAYS      = 4;
  localparam int TLB_LINES = 8;
  localparam int C_LINES   = 256;
  localparam int LINE_BITS = 128;
  typedef enum logic [1:0] {
    CT_BUF = 2'h0, CT_WRITE = 2'h1, CT_READ = 2'h2, CT_FLUSH = 2'h3
  } tca_cop_type;
  // one test register move from the core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] sel;
    logic [31:0] data;
    logic [1:0] cpl;
    logic       realMode;
  } tca_req_type;
  typedef struct packed {
    logic [31:0]  tlbData;
    logic [31:0]  tlbCtrl;
    logic [31:0]  cacheCtrl;
    logic [31:0]  cacheTag;
    logic [127:0] fill;
    logic [127:0] flush;
    logic [31:0]  rdData;
    logic         rdValid;
    logic         fault;
    logic         tlbGo;
    logic         cacheGo;
  } tca_state_type;
endpackage

// File: verification/tlb_cache_test_access_test.sv
// self-checking bench for the tlb and cache test access block
`timescale 1ns/100ps
module tlb_cache_test_access_test;
  import tca_pkg::*;
  logic        clk;
  logic        reset;
  tca_req_type req;
  logic        coreWr;
  logic [31:0] coreAddr;
  logic [31:0] coreData;
  logic [31:0] rdData;
  logic        rdValid;
  logic        fault;
  int          miscompares;
  int          totalChecks;
  logic        faultSeen;
  logic [31:0] got;

  tca_tlb_cache_test i_tca_tlb_cache_test (
    .clk      (clk),
    .reset    (reset),
    .req      (req),
    .coreWr   (coreWr),
    .coreAddr (coreAddr),
    .coreData (coreData),
    .rdData   (rdData),
    .rdValid  (rdValid),
    .fault    (fault)
  );

  // ****************************************
  // clock and helper tasks
  // ****************************************
  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e,
                          input logic [31:0] m);
    totalChecks++;
    if ((g & m) !== (e & m)) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, g & m, e & m);
    end
  endtask

  task automatic cmp_bit(input logic g, input logic e);
    totalChecks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one-cycle write pulse, then a gap so a started op is never overrun
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    req.wr = 1'b1;
    req.sel = s;
    req.data = d;
    @(negedge clk);
    faultSeen = fault;
    req.wr = 1'b0;
    @(negedge clk);
    faultSeen = faultSeen | fault;
  endtask

  // read pulse; the answer is awaited under a bounded count
  task automatic rd(input logic [2:0] s, output logic [31:0] d);
    int i;
    req.rd = 1'b1;
    req.sel = s;
    @(negedge clk);
    req.rd = 1'b0;
    i = 0;
    while (rdValid !== 1'b1 && i < 4) begin
      @(negedge clk);
      i++;
    end
    cmp_bit(rdValid, 1'b1);
    d = rdData;
    @(negedge clk);
  endtask

  task automatic chk(input logic [2:0] s, input logic [31:0] e,
                     input logic [31:0] m);
    rd(s, got);
    cmp_word(got, e, m);
  endtask

  // control write starts the operation; results need one more edge
  task automatic op(input logic [2:0] s, input logic [31:0] d);
    wr(s, d);
    idle(3);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    miscompares = 0;
    totalChecks = 0;
    reset = 1'b1;
    req = '0;
    coreWr = 1'b0;
    coreAddr = 32'h00000000;
    coreData = 32'h00000000;
    idle(10);
    reset = 1'b0;
    idle(1);
    // cleared registers, unmapped select reads zero
    for (int s = 0; s < 8; s++) chk(3'(s), RST_WORD, 32'hffffffff);
    wr(SEL_TLB_DATA, 32'hffffffff);
    chk(SEL_TLB_DATA, TLB_DATA_MASK, 32'hffffffff);
    // real mode counts as level 0 even with a nonzero level
    req.cpl = 2'h3;
    req.realMode = 1'b1;
    wr(SEL_CT_TAG, 32'hffffffff);
    cmp_bit(faultSeen, 1'b0);
    req.realMode = 1'b0;
    wr(SEL_CT_TAG, 32'h00000000);
    cmp_bit(faultSeen, 1'b1);
    req.cpl = 2'h0;
    chk(SEL_CT_TAG, CT_TAG_MASK, 32'hffffffff);
    // tlb write into set 2 chosen by set select
    wr(SEL_TLB_DATA, 32'habcde018);
    op(SEL_TLB_CTRL, 32'h12345c40);
    // dirty pair: never, zero, one, either; stored dirty bit is one
    for (int dp = 0; dp < 4; dp++) begin
      op(SEL_TLB_CTRL, 32'h123451e1 | (32'(dp) << 9));
      chk(SEL_TLB_DATA, dp[1] ? 32'habcde018 : 32'habcde000,
          32'hfffffc7f);
    end
    chk(SEL_TLB_CTRL, 32'h12345cc1, 32'hffffffff);
    // invalidating write makes the next lookup miss
    op(SEL_TLB_CTRL, 32'h12345040);
    op(SEL_TLB_CTRL, 32'h123457e1);
    chk(SEL_TLB_DATA, 32'habcde000, 32'hfffffc7f);
    // replacement victim from cleared lru is set 0
    wr(SEL_TLB_DATA, 32'h5555500c);
    op(SEL_TLB_CTRL, 32'h22222800);
    op(SEL_TLB_CTRL, 32'h222227e1);
    chk(SEL_TLB_DATA, 32'h55555010, 32'hfffffc7f);
    // the write just made set 0 the most recent: bits 0 and 1 set
    chk(SEL_TLB_DATA, 32'h55555180, 32'h00000380);
    // fill four words of line 0x5a, write them into set 1
    for (int n = 0; n < 4; n++) begin
      op(SEL_CT_CTRL, 32'h000005a0 | (32'(n) << 2));
      wr(SEL_CT_DATA, 32'hc0de0000 | 32'(n));
    end
    wr(SEL_CT_TAG, 32'h13579400);
    op(SEL_CT_CTRL, 32'h000005a5);
    op(SEL_CT_CTRL, 32'h000005a6);
    chk(SEL_CT_TAG, 32'h13579400, 32'hfffffc7f);
    for (int n = 0; n < 4; n++) begin
      op(SEL_CT_CTRL, 32'h000005a0 | (32'(n) << 2));
      chk(SEL_CT_DATA, 32'hc0de0000 | 32'(n), 32'hffffffff);
    end
    // internal write to word 2 sets only its dirty bit
    coreAddr = 32'h135795a8;
    coreData = 32'hfeedface;
    coreWr = 1'b1;
    idle(1);
    coreWr = 1'b0;
    idle(1);
    op(SEL_CT_CTRL, 32'h000005a6);
    chk(SEL_CT_TAG, 32'h13579420, 32'hfffffc7f);
    op(SEL_CT_CTRL, 32'h000005a8);
    chk(SEL_CT_DATA, 32'hfeedface, 32'hffffffff);
    // flush drops the valid bit of the line
    op(SEL_CT_CTRL, 32'h000005a7);
    op(SEL_CT_CTRL, 32'h000005a6);
    chk(SEL_CT_TAG, 32'h00000000, 32'h00000400);
    give_verdict();
  end

  // watchdog: the sequence needs well under 10000 cycles
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
